// ===== host_port_map.svh
// Offsets, field positions, lengths and reset values of the host port.
// Included by the package and by every design file that needs a figure.
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// ****************************************************************
// Register address codes on the two address pins
// ****************************************************************
`define ADDR_MSG        2'h0
`define ADDR_CTL        2'h1
`define ADDR_PCM        2'h2
`define ADDR_CMP        2'h3

// ****************************************************************
// Control/status field positions and reserved value
// ****************************************************************
`define CTL_BIT_IN_BUSY 2
`define CTL_BIT_OUT_RDY 1
`define CTL_RESERVED    8'h00

// ****************************************************************
// Exchange lengths
// ****************************************************************
`define BOOT_WR_LEN     3'h3
`define RUN_RESP_LEN    3'h6

// ****************************************************************
// Widths, depth and pin reset values
// ****************************************************************
`define BYTE_W          8
`define FIFO_DEPTH      32
`define FIFO_AW         5
`define PIN_W           13
`define PIN_IDLE        13'h1C00
`define BYTE_ZERO       8'h00

`endif

// ===== host_port_pkg.sv
// Types shared by the host port, its monitor and the bench models.
// Assumes the map header sits in the same folder.
`include "host_port_map.svh"

package host_port_pkg;

	// Raw pin bundle: {cs_n, wr_n, rd_n, addr[1:0], data[7:0]}
	typedef logic [`PIN_W-1:0]  pin_vec_t;
	typedef logic [`BYTE_W-1:0] byte_t;

	// Complete state of the port front end
	typedef struct packed {
		pin_vec_t s1;          // First synchroniser stage
		pin_vec_t s2;          // Second stage
		pin_vec_t s3;          // Third stage
		pin_vec_t filt;        // Agreed pin levels
		pin_vec_t filt_d;      // Agreed levels one cycle back
		byte_t    msg_in;      // Byte written by the host
		byte_t    msg_out;     // Byte waiting for the host
		logic     in_busy;     // Inbound byte not yet taken
		logic     out_rdy;     // Outbound byte valid
		logic     irq_n;       // Message interrupt line
		logic [2:0] boot_wr;   // Boot bytes written since reply
		logic [2:0] run_rd;    // Run-time bytes read in message
		logic     resp_done;   // Whole run-time response read
		byte_t    dout;        // Read data on the pins
		logic     dout_oe;     // Pin drive enable
		byte_t    pcm;         // Last audio data byte
		logic     pcm_stb;     // Audio data strobe
		byte_t    cmp;         // Last compressed data byte
		logic     cmp_stb;     // Compressed data strobe
	} port_state_t;

endpackage

// ===== byte_stream_if.sv
// Valid/ready byte stream joining the port and its response buffer.
// Both ends share one clock; no crossing happens here.
`timescale 1ns/1ps

interface byte_stream_if;
	logic [7:0] data;   // Byte on offer
	logic       valid;  // Offer stands
	logic       ready;  // Taker accepts

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// ===== resp_fifo.sv
// Flip-flop FIFO holding response bytes on their way to the host.
// Assumes one clock; push and pop sides speak valid/ready.
`timescale 1ns/1ps

module resp_fifo #(
	parameter int W  = 8,                  // Word width
	parameter int D  = 32,                 // Depth in words
	parameter int AW = 5                   // Index width
) (
	input  wire logic    clk_i,            // Core clock
	input  wire logic    rst_n_i,          // Sync reset, active low
	input  wire logic    ce_i,             // Clock enable
	input  wire logic [W-1:0] in_data_i,   // Push data
	input  wire logic    in_valid_i,       // Push request
	output logic         in_ready_o,       // Room for a word
	byte_stream_if.src   out_s             // Pop side
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;  // Storage
		logic [AW-1:0] wp;         // Write index
		logic [AW-1:0] rp;         // Read index
		logic [AW:0]   cnt;        // Words held
		logic          nfull;      // Room left
		logic          nempty;     // Word ready
	} fifo_state_t;

	fifo_state_t s_r;    // Registered state
	fifo_state_t s_nxt;  // Next state

	// Flags are registered so in_ready_o and out_s.valid come from flip-flops
	assign in_ready_o   = s_r.nfull;
	assign out_s.valid  = s_r.nempty;
	assign out_s.data   = s_r.mem[s_r.rp];

	// Next state
	always_comb begin
		logic push;
		logic pop;
		logic [AW:0] c;
		push  = in_valid_i & s_r.nfull;
		pop   = out_s.ready & s_r.nempty;
		c     = s_r.cnt;
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data_i;
			s_nxt.wp = s_r.wp + AW'(1);
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + AW'(1);
		end
		// Count moves only when one side acts alone
		if (push && !pop) begin
			c = s_r.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			c = s_r.cnt - (AW+1)'(1);
		end
		s_nxt.cnt    = c;
		s_nxt.nfull  = (c != (AW+1)'(D));
		s_nxt.nempty = (c != '0);
	end

	// Register; storage needs no reset
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_r        <= s_nxt;
			s_r.wp     <= '0;
			s_r.rp     <= '0;
			s_r.cnt    <= '0;
			s_r.nfull  <= 1'b1;
			s_r.nempty <= 1'b0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end
endmodule // resp_fifo

// ===== host_msg_port.sv
// Byte-wide parallel host message port: pin front end, message and
// control/status registers, audio byte strobes, response buffer.
// Assumes pins come from another clock domain and that the DSP side
// runs on clk_i.
`timescale 1ns/1ps

`include "host_port_map.svh"

module host_msg_port (
	input  wire logic  clk_i,                    // Core clock 200 MHz
	input  wire logic  rst_n_i,                  // Sync reset, active low
	input  wire logic  ce_i,                     // Clock enable
	input  wire logic  cs_n_i,                   // Chip select pin
	input  wire logic  wr_n_i,                   // Write strobe pin
	input  wire logic  rd_n_i,                   // Read strobe pin
	input  wire logic [1:0] addr_i,              // Register code pins
	input  wire host_port_pkg::byte_t data_i,    // Data pins in
	output host_port_pkg::byte_t data_o,         // Data pins out
	output logic       data_oe_o,                // Data pins driven
	output logic       message_irq_n_o,          // Message interrupt
	input  wire logic  boot_mode_i,              // Boot exchange phase
	input  wire logic  irq_notify_en_i,          // Notification enabled
	input  wire logic  dsp_in_isr_i,             // DSP in service routine
	output host_port_pkg::byte_t cmd_byte_o,     // Inbound control byte
	output logic       cmd_valid_o,              // Inbound byte waiting
	input  wire logic  cmd_take_i,               // DSP takes the byte
	input  wire host_port_pkg::byte_t resp_byte_i, // Outbound byte
	input  wire logic  resp_valid_i,             // Outbound byte offered
	output logic       resp_ready_o,             // Buffer has room
	output logic       resp_done_o,              // Six-byte reply read
	output logic       input_busy_flag_o,        // Busy status
	output logic       output_ready_flag_o,      // Ready status
	output host_port_pkg::byte_t pcm_input_byte_o,        // Audio byte
	output logic       pcm_strobe_o,             // Audio byte pulse
	output host_port_pkg::byte_t compressed_input_byte_o, // Coded byte
	output logic       compressed_strobe_o       // Coded byte pulse
);
	import host_port_pkg::*;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************

	// Only the message and control codes answer a read
	function automatic logic readable(input logic [1:0] a);
		readable = (a == `ADDR_MSG) || (a == `ADDR_CTL);
	endfunction

	// A strobe is active while chip select and it are both low
	function automatic logic active(input pin_vec_t p, input int idx);
		active = !p[12] && !p[idx];
	endfunction

	// ****************************************************************
	// State and response buffer
	// ****************************************************************
	port_state_t   s_r;     // Registered state
	port_state_t   s_nxt;   // Next state
	byte_stream_if rq ();   // Buffer to message register

	resp_fifo #(
		.W  (`BYTE_W),
		.D  (`FIFO_DEPTH),
		.AW (`FIFO_AW)
	) u_fifo (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.ce_i       (ce_i),
		.in_data_i  (resp_byte_i),
		.in_valid_i (resp_valid_i),
		.in_ready_o (resp_ready_o),
		.out_s      (rq)
	);

	// Outputs straight from state flip-flops
	assign data_o                  = s_r.dout;
	assign data_oe_o               = s_r.dout_oe;
	assign message_irq_n_o         = s_r.irq_n;
	assign cmd_byte_o              = s_r.msg_in;
	assign cmd_valid_o             = s_r.in_busy;
	assign resp_done_o             = s_r.resp_done;
	assign input_busy_flag_o       = s_r.in_busy;
	assign output_ready_flag_o     = s_r.out_rdy;
	assign pcm_input_byte_o        = s_r.pcm;
	assign pcm_strobe_o            = s_r.pcm_stb;
	assign compressed_input_byte_o = s_r.cmp;
	assign compressed_strobe_o     = s_r.cmp_stb;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		logic       wr_end;   // Write cycle just finished
		logic       rd_beg;   // Read cycle just started
		logic       rd_end;   // Read cycle just finished
		logic [1:0] a_old;    // Address held during the cycle
		byte_t      d_old;    // Data held during the cycle
		logic       load;     // Buffer byte moves to message reg
		byte_t      ctl;      // Control/status image
		wr_end = 1'b0;
		rd_beg = 1'b0;
		rd_end = 1'b0;
		a_old  = s_r.filt_d[9:8];
		d_old  = s_r.filt_d[7:0];
		load   = 1'b0;
		ctl    = `CTL_RESERVED;
		s_nxt  = s_r;

		// Three-stage synchroniser; a level counts once 2 and 3 agree
		s_nxt.s1     = {cs_n_i, wr_n_i, rd_n_i, addr_i, data_i};
		s_nxt.s2     = s_r.s1;
		s_nxt.s3     = s_r.s2;
		s_nxt.filt   = (~(s_r.s2 ^ s_r.s3) & s_r.s3)
		             | ((s_r.s2 ^ s_r.s3) & s_r.filt);
		s_nxt.filt_d = s_r.filt;

		// Edges on the agreed levels; data taken from the held copy
		wr_end = active(s_r.filt_d, 11) && !active(s_r.filt, 11);
		rd_beg = !active(s_r.filt_d, 10) && active(s_r.filt, 10);
		rd_end = active(s_r.filt_d, 10) && !active(s_r.filt, 10);

		// Strobes last one cycle
		s_nxt.pcm_stb   = 1'b0;
		s_nxt.cmp_stb   = 1'b0;
		s_nxt.resp_done = 1'b0;

		// DSP consumes the inbound byte, never inside its ISR
		if (cmd_take_i && !dsp_in_isr_i) begin
			s_nxt.in_busy = 1'b0;
		end

		// Host write decode; a set outranks a same-cycle take
		if (wr_end && a_old == `ADDR_MSG) begin
			// Messages and images alike, byte by byte in arrival order
			s_nxt.msg_in  = d_old;
			s_nxt.in_busy = 1'b1;
			if (boot_mode_i && s_r.boot_wr != `BOOT_WR_LEN) begin
				s_nxt.boot_wr = s_r.boot_wr + 3'h1;
			end
		end else if (wr_end && a_old == `ADDR_PCM) begin
			s_nxt.pcm     = d_old;
			s_nxt.pcm_stb = 1'b1;
		end else if (wr_end && a_old == `ADDR_CMP) begin
			s_nxt.cmp     = d_old;
			s_nxt.cmp_stb = 1'b1;
		end

		// Control/status image seen by the host
		ctl[`CTL_BIT_IN_BUSY] = s_r.in_busy;
		ctl[`CTL_BIT_OUT_RDY] = s_r.out_rdy;

		// Read data latched at the start and held to the end
		if (rd_beg) begin
			s_nxt.dout_oe = readable(s_r.filt[9:8]);
			if (s_r.filt[9:8] == `ADDR_MSG) begin
				s_nxt.dout = s_r.msg_out;
			end else if (s_r.filt[9:8] == `ADDR_CTL) begin
				s_nxt.dout = ctl;
			end else begin
				s_nxt.dout = `BYTE_ZERO;
			end
		end else if (rd_end) begin
			s_nxt.dout_oe = 1'b0;
		end

		// Completed read of the message register frees it
		if (rd_end && a_old == `ADDR_MSG && s_r.out_rdy) begin
			s_nxt.out_rdy = 1'b0;
			if (!boot_mode_i) begin
				// Count bytes of a run-time reply
				if (s_r.run_rd == `RUN_RESP_LEN - 3'h1) begin
					s_nxt.run_rd    = 3'h0;
					s_nxt.resp_done = 1'b1;
				end else begin
					s_nxt.run_rd = s_r.run_rd + 3'h1;
				end
			end
		end

		// Refill message register; boot waits for the three writes.
		// A read end and a load never meet: load needs ready low.
		if (!s_r.out_rdy && rq.valid) begin
			load = !boot_mode_i || s_r.boot_wr == `BOOT_WR_LEN;
		end
		rq.ready = load;
		if (load) begin
			s_nxt.msg_out = rq.data;
			s_nxt.out_rdy = 1'b1;
			if (boot_mode_i) begin
				s_nxt.boot_wr = 3'h0;
			end
		end

		// Interrupt mirrors ready when enabled, silent during boot
		s_nxt.irq_n = !(irq_notify_en_i && !boot_mode_i
		                && s_nxt.out_rdy);
		if (boot_mode_i) begin
			s_nxt.run_rd = 3'h0;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// Reset leaves every flag idle and pins released
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_r           <= '0;
			s_r.s1        <= `PIN_IDLE;
			s_r.s2        <= `PIN_IDLE;
			s_r.s3        <= `PIN_IDLE;
			s_r.filt      <= `PIN_IDLE;
			s_r.filt_d    <= `PIN_IDLE;
			s_r.irq_n     <= 1'b1;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end
endmodule // host_msg_port

// ===== host_port_monitor.sv
// Timing checks on the host message port outputs.
// Bound into host_msg_port; sees its ports only.
`timescale 1ns/1ps

module host_port_monitor (
	input wire logic clk_i,                 // Clock
	input wire logic rst_n_i,               // Reset
	input wire logic cs_n_i,                // Select pin
	input wire logic wr_n_i,                // Write pin
	input wire logic rd_n_i,                // Read pin
	input wire logic [1:0] addr_i,          // Code pins
	input wire host_port_pkg::byte_t data_o, // Read data
	input wire logic data_oe_o,             // Drive
	input wire logic message_irq_n_o,       // Irq line
	input wire logic boot_mode_i,           // Boot
	input wire logic irq_notify_en_i,       // Notify
	input wire logic dsp_in_isr_i,          // In ISR
	input wire logic cmd_valid_o,           // Inbound
	input wire logic cmd_take_i,            // Take
	input wire logic resp_done_o,           // Reply read
	input wire logic input_busy_flag_o,     // Busy
	input wire logic output_ready_flag_o    // Ready
);
	import host_port_pkg::*;
	// ********
	// One domain, so one default clock
	// ********
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_read_start;
		$fell(rd_n_i) && !cs_n_i && !addr_i[1];
	endsequence
	sequence s_notify;
		output_ready_flag_o && irq_notify_en_i && !boot_mode_i;
	endsequence
	// Synchronisers give a few edges of slack
	AST_READ_ANS: assert property (s_read_start |-> ##[4:6] data_oe_o)
		else $error("read not answered");
	AST_RST_IDLE: assert property ($rose(rst_n_i) |-> !input_busy_flag_o &&
		!output_ready_flag_o && message_irq_n_o && !data_oe_o)
		else $error("port not idle after reset");
	AST_BUSY_SET: assert property ($rose(wr_n_i) && !$past(cs_n_i) &&
		addr_i == 2'h0 |-> ##[4:6] input_busy_flag_o)
		else $error("busy not set by message write");
	AST_ISR_HOLD: assert property (cmd_valid_o && dsp_in_isr_i |=> cmd_valid_o)
		else $error("byte taken during service");
	AST_TAKE: assert property (cmd_valid_o && cmd_take_i && !dsp_in_isr_i
		|=> !cmd_valid_o) else $error("busy not cleared");
	AST_RD_CODE: assert property ($rose(data_oe_o) |-> !addr_i[1])
		else $error("drove a write-only code");
	AST_CTL_FMT: assert property ($rose(data_oe_o) && addr_i == 2'h1
		|-> data_o[7:3] == 5'h00 && !data_o[0]) else $error("status bits");
	AST_IRQ_SRC: assert property (!message_irq_n_o |-> output_ready_flag_o)
		else $error("irq without message");
	AST_IRQ_ON: assert property (s_notify ##1 s_notify |-> !message_irq_n_o)
		else $error("irq not asserted");
	AST_BOOT_IRQ: assert property (boot_mode_i && $past(boot_mode_i)
		|-> message_irq_n_o) else $error("irq during boot");
	AST_DONE: assert property (resp_done_o |-> !boot_mode_i ##1 !resp_done_o)
		else $error("done pulse");
endmodule // host_port_monitor

bind host_msg_port host_port_monitor mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.cs_n_i(cs_n_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .addr_i(addr_i),
	.data_o(data_o),
	.data_oe_o(data_oe_o), .message_irq_n_o(message_irq_n_o),
	.boot_mode_i(boot_mode_i), .irq_notify_en_i(irq_notify_en_i),
	.dsp_in_isr_i(dsp_in_isr_i), .cmd_valid_o(cmd_valid_o),
	.cmd_take_i(cmd_take_i), .resp_done_o(resp_done_o),
	.input_busy_flag_o(input_busy_flag_o),
	.output_ready_flag_o(output_ready_flag_o));

// ===== host_bus_model.sv
// Host microcontroller on the byte-wide pin bus.
// Slow strobes (8 clocks) so the synchronisers always agree.
`timescale 1ns/1ps

module host_bus_model (
	input  wire logic clk_i,                 // Clock
	input  wire host_port_pkg::byte_t rd_i,  // Device data
	input  wire logic oe_i,                  // Device drives
	output logic cs_n_o,                     // Select
	output logic wr_n_o,                     // Write
	output logic rd_n_o,                     // Read
	output logic [1:0] addr_o,               // Code
	output host_port_pkg::byte_t data_o      // Host data
);
	import host_port_pkg::*;
	// Idle pins from time zero
	initial begin
		cs_n_o = 1'b1;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		addr_o = 2'h1;
		data_o = 8'hA5;
	end
	// One byte, caller sends MSB first; never while busy
	task automatic put(input logic [1:0] a, input byte_t d);
		@(posedge clk_i);
		addr_o <= a;
		data_o <= d;
		cs_n_o <= 1'b0;
		wr_n_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		cs_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		data_o <= ~d; // Released bus must not keep the byte
		repeat (6) @(posedge clk_i);
	endtask
	task automatic get(input logic [1:0] a, output byte_t v, output logic oe);
		@(posedge clk_i);
		addr_o <= a;
		cs_n_o <= 1'b0;
		rd_n_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		v = rd_i;
		oe = oe_i;
		cs_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask
	// Status poll until output-ready, bounded
	task automatic poll(output byte_t s);
		logic oe;
		s = 8'h00;
		for (int i = 0; i < 60 && !s[1]; i++) get(2'h1, s, oe);
	endtask
endmodule // host_bus_model

// ===== testbench.sv
// Self-checking bench for host_msg_port with a host pin model.
// Reference queue predicts every byte of the filled reply buffer.
`timescale 1ns/1ps

module testbench;
	import host_port_pkg::*;
	logic  clk_i, rst_n_i, boot, notify, isr, take, rvalid, seen_oe;
	logic  cs_n, wr_n, rd_n, oe, irq_n, cvalid, rready, done, ce;
	logic  busy, rdy, pcm_s, cmp_s;
	logic  [1:0] addr;
	byte_t rbyte, hdata, rdata, bus, cbyte, pcm_b, cmp_b, v, b;
	int    n_errors, n_tests, n_done, pcm_seen, cmp_seen, k, n, q[$];

	assign bus = oe ? rdata : hdata;
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Catch one-cycle pulses
	always @(posedge clk_i) begin
		if (done === 1'b1) n_done++;
		if (pcm_s === 1'b1) pcm_seen = pcm_b;
		if (cmp_s === 1'b1) cmp_seen = cmp_b;
	end
	host_msg_port uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
		.cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n), .addr_i(addr),
		.data_i(bus), .data_o(rdata), .data_oe_o(oe), .message_irq_n_o(irq_n),
		.boot_mode_i(boot), .irq_notify_en_i(notify), .dsp_in_isr_i(isr),
		.cmd_byte_o(cbyte), .cmd_valid_o(cvalid), .cmd_take_i(take),
		.resp_byte_i(rbyte), .resp_valid_i(rvalid), .resp_ready_o(rready),
		.resp_done_o(done), .input_busy_flag_o(busy),
		.output_ready_flag_o(rdy), .pcm_input_byte_o(pcm_b),
		.pcm_strobe_o(pcm_s), .compressed_input_byte_o(cmp_b),
		.compressed_strobe_o(cmp_s));
	host_bus_model host (.clk_i(clk_i), .rd_i(rdata), .oe_i(oe),
		.cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .addr_o(addr),
		.data_o(hdata));

	task automatic chk(input byte_t seen, input byte_t exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (n_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
	endtask
	// DSP raises take for the inbound byte, maybe from inside a service routine
	task automatic take_byte(input logic in_isr);
		@(posedge clk_i);
		isr <= in_isr;
		take <= 1'b1;
		@(posedge clk_i);
		isr <= 1'b0;
		take <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	// Watchdog well beyond the expected run
	initial begin
		repeat (80000) @(posedge clk_i);
		n_errors++;
		finish_test();
	end

	initial begin
		k = $urandom(32'h2BB1);
		{rst_n_i, boot, isr, take, rvalid, rbyte} = '0;
		{notify, ce} = 2'b11;
		do_reset();
		chk({4'h0, busy, rdy, irq_n, oe}, 8'h02);
		for (int i = 0; i < 3; i++) begin
			b = $urandom;
			host.put(2'h0, b);
			chk(cbyte, b);
			host.get(2'h1, v, seen_oe);
			chk(v, 8'h04);
			take_byte(1'b1);
			chk({7'h00, busy}, 8'h01);
			take_byte(1'b0);
			chk({7'h00, busy}, 8'h00);
		end
		for (int a = 2; a < 4; a++) begin
			b = $urandom;
			host.put(a[1:0], b);
			chk(8'(a == 2 ? pcm_seen : cmp_seen), b);
			host.get(a[1:0], v, seen_oe);
			chk({7'h00, seen_oe}, 8'h00);
		end
		// Fill the reply buffer with the host stalled
		@(posedge clk_i);
		rvalid <= 1'b1;
		b = $urandom;
		rbyte <= b;
		for (k = 0; k < 40; k++) begin
			@(posedge clk_i);
			if (rready !== 1'b1) break;
			q.push_back(rbyte);
			b = $urandom;
			rbyte <= b;
		end
		rvalid <= 1'b0;
		chk({7'h00, rready}, 8'h00);
		n = q.size();
		n_done = 0;
		while (q.size() > 0) begin
			host.poll(v);
			chk(v & 8'h02, 8'h02);
			chk({7'h00, irq_n}, 8'h00);
			host.get(2'h0, v, seen_oe);
			chk(v, 8'(q.pop_front()));
		end
		chk(8'(n_done), 8'(n / 6));
		host.get(2'h1, v, seen_oe);
		chk(v, 8'h00);
		// Unsolicited byte with notification off, found by the late poll
		notify <= 1'b0;
		rvalid <= 1'b1;
		b = $urandom;
		rbyte <= b;
		@(posedge clk_i);
		rvalid <= 1'b0;
		repeat (20000) @(posedge clk_i);
		host.get(2'h1, v, seen_oe);
		chk(v, 8'h02);
		chk({7'h00, irq_n}, 8'h01);
		host.get(2'h0, v, seen_oe);
		chk(v, b);
		// Boot: three bytes in before the single reply
		boot <= 1'b1;
		notify <= 1'b1;
		do_reset();
		b = $urandom;
		rvalid <= 1'b1;
		rbyte <= b;
		@(posedge clk_i);
		rvalid <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			host.put(2'h0, 8'($urandom));
			take_byte(1'b0);
			host.get(2'h1, v, seen_oe);
			chk(v, i < 2 ? 8'h00 : 8'h02);
		end
		chk({7'h00, irq_n}, 8'h01);
		host.get(2'h0, v, seen_oe);
		chk(v, b);
		// Clock enable low: an audio write must leave no trace
		n = pcm_seen;
		ce <= 1'b0;
		host.put(2'h2, ~8'(n));
		ce <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk(8'(pcm_seen), 8'(n));
		finish_test();
	end
endmodule // testbench
